// ---- pkg/rps_pkg.sv ----
// Package of constants for the remappable output pin selector
package rps_pkg;
   localparam int           RPS_NUM_REGS   = 8;
   localparam int           RPS_NUM_PINS   = 16;
   localparam int           RPS_FIRST_PIN  = 16;
   localparam int           RPS_SEL_W      = 6;
   localparam int           RPS_REG_W      = 16;
   localparam int           RPS_ADDR_W     = 5;
   localparam int           RPS_EVEN_LSB   = 0;
   localparam int           RPS_ODD_LSB    = 8;
   localparam logic [15:0]  RPS_IMPL_MASK  = 16'h3f3f;
   localparam logic [15:0]  RPS_LAST_MASK_SMALL = 16'h003f;
   localparam logic [5:0]   RPS_SEL_RESET  = 6'h00;
   localparam logic [4:0]   RPS_BASE_OFFSET = 5'h00;
   localparam logic [4:0]   RPS_LAST_OFFSET = 5'h1c;
   localparam logic [31:0]  RPS_UNMAPPED_DATA = 32'h0000_0000;
   typedef enum logic [1:0] {RPS_PKG_LARGE, RPS_PKG_MID, RPS_PKG_SMALL} rps_pkg_e;
endpackage

// ---- hdl/rps_out_select.sv ----
// Remappable output pin selector with Avalon-MM register slave
//
// The address map and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module rps_out_select
   import rps_pkg::*;
#(
   parameter int FUNC_COUNT   = 64,
   parameter bit HAS_PIN31    = 1'b1
)
(
   input  wire logic                              clk_in,
   input  wire logic                              rst_n_in,
   input  wire logic                              clk_en_in,
   input  wire logic [RPS_ADDR_W-1:0]             avs_address_in,
   input  wire logic                              avs_read_in,
   input  wire logic                              avs_write_in,
   input  wire logic [31:0]                       avs_writedata_in,
   input  wire logic [3:0]                        avs_byteenable_in,
   output logic      [31:0]                       avs_readdata_out,
   output logic                                   avs_waitrequest_out,
   output logic      [1:0]                        avs_response_out,
   input  wire logic [FUNC_COUNT-1:0]             periph_out_in,
   output logic      [RPS_NUM_PINS-1:0]           pin_out,
   output logic      [RPS_NUM_PINS*RPS_SEL_W-1:0] pin_select_out
);

   ////////////////////////////////////////////////////////////////////////////
   // Registers
   logic [RPS_REG_W-1:0] sel_reg [RPS_NUM_REGS];
   logic [RPS_REG_W-1:0] sel_next [RPS_NUM_REGS];
   logic                 ack_reg;
   logic                 ack_next;
   logic [31:0]          rdata_reg;
   logic [31:0]          rdata_next;
   logic [1:0]           resp_reg;
   logic [1:0]           resp_next;
   logic [RPS_NUM_PINS-1:0] pin_reg;
   logic [RPS_NUM_PINS-1:0] pin_next;

   logic                 req;
   logic                 done;
   logic                 hit;
   logic [2:0]           idx;
   logic [15:0]          be_mask;
   logic [15:0]          wr_mask [RPS_NUM_REGS];

   ////////////////////////////////////////////////////////////////////////////
   // Decode
   assign req     = (avs_read_in | avs_write_in) & ~ack_reg;
   assign done    = (avs_read_in | avs_write_in) & ack_reg;
   assign hit     = (avs_address_in[1:0] == 2'h0) && (avs_address_in <= RPS_LAST_OFFSET);
   assign idx     = avs_address_in[4:2];
   assign be_mask = {{8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};

   always_comb
   begin
      for (int r = 0; r < RPS_NUM_REGS; r++)
      begin
         wr_mask[r] = RPS_IMPL_MASK;
      end
      if (!HAS_PIN31)
      begin
         wr_mask[RPS_NUM_REGS-1] = RPS_LAST_MASK_SMALL;
      end
   end

   always_comb
   begin
      ack_next   = req;
      rdata_next = rdata_reg;
      resp_next  = resp_reg;
      for (int r = 0; r < RPS_NUM_REGS; r++)
      begin
         sel_next[r] = sel_reg[r];
      end
      if (req)
      begin
         resp_next  = hit ? 2'h0 : 2'h3;
         rdata_next = RPS_UNMAPPED_DATA;
         if (hit && avs_read_in)
         begin
            rdata_next = {16'h0000, sel_reg[idx] & wr_mask[idx]};
         end
      end
      // Write lands on the edge after the wait state, in the cycle with waitrequest low
      if (done && hit && avs_write_in)
      begin
         sel_next[idx] = (sel_reg[idx] & ~(wr_mask[idx] & be_mask))
                       | (avs_writedata_in[15:0] & wr_mask[idx] & be_mask);
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         for (int r = 0; r < RPS_NUM_REGS; r++)
         begin
            sel_reg[r] <= {RPS_REG_W{1'b0}};
         end
         ack_reg   <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         resp_reg  <= 2'h0;
      end
      else if (clk_en_in)
      begin
         for (int r = 0; r < RPS_NUM_REGS; r++)
         begin
            sel_reg[r] <= sel_next[r];
         end
         ack_reg   <= ack_next;
         rdata_reg <= rdata_next;
         resp_reg  <= resp_next;
      end
   end

   assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~(ack_reg & clk_en_in);
   assign avs_readdata_out    = rdata_reg;
   assign avs_response_out    = resp_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Pin routing
   always_comb
   begin
      logic [RPS_SEL_W-1:0] s;
      s = '0;
      for (int p = 0; p < RPS_NUM_PINS; p++)
      begin
         s = sel_reg[p/2][(p%2)*RPS_ODD_LSB +: RPS_SEL_W];
         pin_select_out[p*RPS_SEL_W +: RPS_SEL_W] = s;
         pin_next[p] = (int'(s) < FUNC_COUNT) ? periph_out_in[s] : 1'b0;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         pin_reg <= '0;
      end
      else if (clk_en_in)
      begin
         pin_reg <= pin_next;
      end
   end

   assign pin_out = pin_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   property p_reserved_zero;
      @(posedge clk_in) disable iff (!rst_n_in)
      ack_reg |=> (rdata_reg[15:14] == 2'h0) && (rdata_reg[7:6] == 2'h0);
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits nonzero");

   property p_reserved_store;
      @(posedge clk_in) disable iff (!rst_n_in)
      (sel_reg[idx][15:14] == 2'h0) && (sel_reg[idx][7:6] == 2'h0);
   endproperty
   a_reserved_store: assert property (p_reserved_store) else $error("reserved bits stored");

   property p_write_read;
      logic [15:0] d;
      @(posedge clk_in) disable iff (!rst_n_in)
      (clk_en_in && done && hit && avs_write_in && avs_byteenable_in[1:0] == 2'h3,
       d = avs_writedata_in[15:0] & wr_mask[idx])
      |=> (sel_reg[$past(idx)] == d);
   endproperty
   a_write_read: assert property (p_write_read) else $error("write not stored");

   property p_pin31_absent;
      @(posedge clk_in) disable iff (!rst_n_in)
      !HAS_PIN31 |-> sel_reg[RPS_NUM_REGS-1][13:8] == 6'h00;
   endproperty
   a_pin31_absent: assert property (p_pin31_absent) else $error("pin 31 field present");

   property p_route;
      @(posedge clk_in) disable iff (!rst_n_in)
      clk_en_in && sel_reg[0][5:0] < FUNC_COUNT
      |=> pin_out[0] == $past(periph_out_in[sel_reg[0][5:0]]);
   endproperty
   a_route: assert property (p_route) else $error("pin 16 misrouted");

   property p_odd_field;
      @(posedge clk_in) disable iff (!rst_n_in)
      pin_select_out[RPS_SEL_W +: RPS_SEL_W] == sel_reg[0][13:8];
   endproperty
   a_odd_field: assert property (p_odd_field) else $error("odd field misplaced");

   property p_answer;
      @(posedge clk_in) disable iff (!rst_n_in)
      clk_en_in && req |=> !clk_en_in || !avs_waitrequest_out;
   endproperty
   a_answer: assert property (p_answer) else $error("no answer in one cycle");

   property p_no_spurious;
      @(posedge clk_in) disable iff (!rst_n_in)
      clk_en_in && !(done && avs_write_in && hit) |=> sel_reg[0] == $past(sel_reg[0]);
   endproperty
   a_no_spurious: assert property (p_no_spurious) else $error("field changed unwritten");

   property p_take_no_write;
      @(posedge clk_in) disable iff (!rst_n_in)
      clk_en_in && req |=> sel_reg[$past(idx)] == $past(sel_reg[idx]);
   endproperty
   a_take_no_write: assert property (p_take_no_write) else $error("write landed while waiting");

   property p_freeze;
      @(posedge clk_in) disable iff (!rst_n_in)
      !clk_en_in |=> (pin_out == $past(pin_out)) && (avs_readdata_out == $past(avs_readdata_out));
   endproperty
   a_freeze: assert property (p_freeze) else $error("state moved while disabled");

   property p_wait_frozen;
      @(posedge clk_in) disable iff (!rst_n_in)
      (avs_read_in || avs_write_in) && !clk_en_in |-> avs_waitrequest_out;
   endproperty
   a_wait_frozen: assert property (p_wait_frozen) else $error("answer given while disabled");

   c_freeze: cover property (@(posedge clk_in) !clk_en_in && avs_waitrequest_out);

   c_write: cover property (@(posedge clk_in) req && avs_write_in && hit);
   c_read:  cover property (@(posedge clk_in) req && avs_read_in && hit);
   c_bad:   cover property (@(posedge clk_in) req && !hit);
   c_route: cover property (@(posedge clk_in) pin_out[15]);

endmodule
`default_nettype wire

// ---- testbench/rps_out_select_tb.sv ----
// Testbench for the remappable output pin selector
`timescale 1ns/1ps
`default_nettype none
module rps_out_select_tb;
   import rps_pkg::*;
   logic        clk_in = 1'b0;
   logic        rst_n_in = 1'b0;
   logic [4:0]  adr = 5'h00;
   logic        rd = 1'b0;
   logic        wr = 1'b0;
   logic [31:0] wdat = 32'h0000_0000;
   logic [63:0] periph = 64'h0123_4567_89ab_cdef;
   logic        ce = 1'b1;
   logic [3:0]  be = 4'hf;
   logic [31:0] rdat, rdat_s, got, got_s;
   logic [1:0]  resp, got_r;
   logic        wreq;
   logic [15:0] pins;
   logic [95:0] sel;
   int          num_errors = 0;
   int          num_checks = 0;
   always #2 clk_in = ~clk_in;
   rps_out_select #(.HAS_PIN31(1'b1)) DUT (.clk_in(clk_in), .rst_n_in(rst_n_in),
      .clk_en_in(ce), .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
      .avs_writedata_in(wdat), .avs_byteenable_in(be), .avs_readdata_out(rdat),
      .avs_waitrequest_out(wreq), .avs_response_out(resp), .periph_out_in(periph),
      .pin_out(pins), .pin_select_out(sel));
   rps_out_select #(.HAS_PIN31(1'b0)) DUT_SMALL (.clk_in(clk_in), .rst_n_in(rst_n_in),
      .clk_en_in(ce), .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
      .avs_writedata_in(wdat), .avs_byteenable_in(be), .avs_readdata_out(rdat_s),
      .avs_waitrequest_out(), .avs_response_out(), .periph_out_in(periph),
      .pin_out(), .pin_select_out());
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] act);
      num_checks++;
      if (act !== exp)
      begin
         num_errors++;
         $display("Error %s expected %h seen %h", name, exp, act);
      end
   endtask
   task automatic bus(input logic w, input logic [4:0] a, input logic [15:0] d);
      int n;
      n = 0;
      @(posedge clk_in);
      adr <= a;
      rd <= !w;
      wr <= w;
      wdat <= {16'h0000, d};
      do
      begin
         @(posedge clk_in);
         n++;
      end
      while (wreq !== 1'b0 && n < 20);
      if (n == 20)
      begin
         num_errors++;
         $display("Error waitrequest expected 0 seen 1");
      end
      got = rdat;
      got_s = rdat_s;
      got_r = resp;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset_values;
      for (int i = 0; i < 8; i++)
      begin
         bus(1'b0, 5'(i * 4), 16'h0000);
         chk("reset read", 32'h0000_0000, got);
      end
      chk("reset pins", {16'h0000, {16{periph[0]}}}, {16'h0000, pins});
   endtask
   task automatic t_reserved_bits;
      for (int i = 0; i < 8; i++)
      begin
         bus(1'b1, 5'(i * 4), 16'hffff);
         bus(1'b0, 5'(i * 4), 16'h0000);
         chk("masked read", 32'h0000_3f3f, got);
         chk("small read", (i == 7) ? 32'h0000_003f : 32'h0000_3f3f, got_s);
      end
   endtask
   task automatic t_route;
      logic [15:0] exp;
      logic [5:0]  s;
      for (int i = 0; i < 8; i++)
      begin
         bus(1'b1, 5'(i * 4), {2'b00, 6'(60 - 6 * i), 2'b00, 6'(63 - 6 * i)});
         bus(1'b0, 5'(i * 4), 16'h0000);
         chk("field read", {16'h0000, 2'b00, 6'(60 - 6 * i), 2'b00, 6'(63 - 6 * i)}, got);
      end
      for (int p = 0; p < 2; p++)
      begin
         @(posedge clk_in);
         periph <= (p == 0) ? 64'h0123_4567_89ab_cdef : 64'hfedc_ba98_7654_3210;
         repeat (3) @(posedge clk_in);
         for (int k = 0; k < 16; k++)
         begin
            s = 6'(63 - 3 * k);
            exp[k] = periph[s];
            chk("select field", {26'h0, s}, {26'h0, sel[k * 6 +: 6]});
         end
         chk("pin routing", {16'h0000, exp}, {16'h0000, pins});
      end
   endtask
   task automatic t_unmapped;
      bus(1'b1, 5'h02, 16'h1111);
      bus(1'b0, 5'h02, 16'h0000);
      chk("unmapped resp", 32'h0000_0003, {30'h0, got_r});
      chk("unmapped data", 32'h0000_0000, got);
      bus(1'b0, 5'h00, 16'h0000);
      chk("kept field", 32'h0000_3c3f, got);
      chk("okay resp", 32'h0000_0000, {30'h0, got_r});
   endtask
   task automatic t_byte_lanes;
      be <= 4'h1;
      bus(1'b1, 5'h04, 16'h2a2a);
      be <= 4'h2;
      bus(1'b1, 5'h04, 16'h1515);
      be <= 4'hf;
      bus(1'b0, 5'h04, 16'h0000);
      chk("lane write", 32'h0000_152a, got);
   endtask
   task automatic t_clock_enable;
      logic [15:0] held;
      @(posedge clk_in);
      ce <= 1'b0;
      periph <= ~periph;
      @(posedge clk_in);
      held = pins;
      fork
         bus(1'b1, 5'h08, 16'h0505);
         begin
            repeat (4) @(posedge clk_in);
            chk("frozen pins", {16'h0000, held}, {16'h0000, pins});
            chk("frozen wait", 32'h0000_0001, {31'h0, wreq});
            ce <= 1'b1;
         end
      join
      bus(1'b0, 5'h08, 16'h0000);
      chk("resumed write", 32'h0000_0505, got);
      repeat (2) @(posedge clk_in);
      chk("resumed pins", {30'h0, periph[5], periph[5]}, {30'h0, pins[5:4]});
   endtask
   task automatic t_mid_reset;
      @(posedge clk_in);
      rst_n_in <= 1'b0;
      repeat (3) @(posedge clk_in);
      rst_n_in <= 1'b1;
      t_reset_values();
   endtask
   task automatic print_verdict;
      if (num_errors == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (16) @(posedge clk_in);
      rst_n_in <= 1'b1;
      t_reset_values();
      t_reserved_bits();
      t_route();
      t_unmapped();
      t_byte_lanes();
      t_clock_enable();
      t_mid_reset();
      print_verdict();
   end
   initial
   begin
      #20000;
      num_errors++;
      print_verdict();
   end
endmodule
`default_nettype wire
